// ---- src/srb_top.sv ----
// Receive buffer, status flags, interrupt and Avalon-MM register slave.
`timescale 1ns/1ps
`include "srb_defines.svh"
module srb_top (
   // Clock and reset.
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // Avalon-MM register slave.
   input  wire logic [2:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire srb_pkg::srb_word_type avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output srb_pkg::srb_word_type      avs_readdata,
   output logic                       avs_waitrequest,
   // Serial link pins.
   input  wire logic                  spi_clk_pin,
   input  wire logic                  spi_cs_n_pin,
   input  wire logic                  serial_data_in_pin,
   input  wire logic                  master_out_pin,
   input  wire logic                  slave_out_pin,
   // Shift engine side.
   input  wire logic                  tx_bit,
   input  wire srb_pkg::srb_cs_type   chip_select_number,
   // Interrupt.
   output logic                       irq
);
   import srb_pkg::*;

   srb_if lk ();

   // Pin synchronisation.
   logic [4:0] pins_s;

   srb_sync #(
      .WIDTH   (5),
      .RST_VAL (`SRB_PIN_RST)
   ) u_sync (
      .mclk   (mclk),
      .srst   (srst),
      .pins   ({spi_clk_pin, spi_cs_n_pin, serial_data_in_pin,
                master_out_pin, slave_out_pin}),
      .pins_s (pins_s)
   );

   srb_shift u_shift (
      .mclk (mclk),
      .srst (srst),
      .lk   (lk)
   );

   // Registers.
   srb_bus_type  st_q;
   srb_word_type rdata_q;
   logic         wait_q;
   logic         irq_q;
   srb_data_type data_q;
   srb_cs_type   lcs_q;
   srb_cs_type   cs_hold_q;
   logic         empty_q;
   logic         ovr_q;
   logic         berr_q;
   srb_flag_type flg_q;
   srb_flag_type inten_q;
   srb_len_type  len_q;
   logic         master_q;

   // The readback pin is the master-out pin in the master role, else the slave-out pin.
   assign lk.sclk_s   = pins_s[4];
   assign lk.cs_n_s   = pins_s[3];
   assign lk.sdi_s    = pins_s[2];
   assign lk.txpin_s  = master_q ? pins_s[1] : pins_s[0];
   assign lk.tx_bit   = tx_bit;
   assign lk.char_len = len_q;

   // Bus decode.
   wire rd_take = (st_q == SRB_BUS_IDLE) & avs_read;
   wire wr_take = (st_q == SRB_BUS_ANSWER) & avs_write;
   wire adr_buf = avs_address == `SRB_ADR_BUF;
   wire adr_mir = avs_address == `SRB_ADR_MIRROR;
   wire adr_flg = avs_address == `SRB_ADR_FLAG;
   wire adr_ien = avs_address == `SRB_ADR_INTEN;
   wire adr_ctl = avs_address == `SRB_ADR_CTRL;
   wire buf_rd  = rd_take & adr_buf;
   wire mir_rd  = rd_take & adr_mir;
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wmask   = avs_writedata & be_mask;
   wire flg_wr  = wr_take & adr_flg;
   wire ien_wr  = wr_take & adr_ien & avs_byteenable[0];
   wire ctl_wr0 = wr_take & adr_ctl & avs_byteenable[0];
   wire ctl_wr1 = wr_take & adr_ctl & avs_byteenable[1];

   // Read data views; reserved bits are tied to zero.
   wire srb_word_type buf_view = {empty_q, ovr_q, 1'b0, berr_q,
                                  10'h000, lcs_q, data_q};
   wire srb_word_type mir_view = {16'h0000, data_q};
   wire srb_word_type flg_view = {29'h0000_0000, flg_q};
   wire srb_word_type ien_view = {29'h0000_0000, inten_q};
   wire srb_word_type ctl_view = {23'h00_0000, master_q, 3'h0, len_q};
   wire srb_word_type rd_mux =
      adr_buf ? buf_view :
      adr_mir ? mir_view :
      adr_flg ? flg_view :
      adr_ien ? ien_view :
      adr_ctl ? ctl_view : 32'h0000_0000;

   // Status next values; a hardware set always beats a read clear.
   wire empty_d = lk.done ? 1'b0 : (buf_rd ? 1'b1 : empty_q);
   wire ovr_set = lk.done & ~empty_q;
   wire ovr_d   = ovr_set ? 1'b1 : (buf_rd ? 1'b0 : ovr_q);
   wire berr_d  = lk.bit_error_status ? 1'b1 : (buf_rd ? 1'b0 : berr_q);

   // Flag register: set by events, cleared by a written one; a buffer read clears only the receive and overrun flags.
   wire srb_flag_type flg_set = {lk.done, ovr_set, lk.bit_error_status};
   wire srb_flag_type flg_wclr = flg_wr ? wmask[2:0] : 3'h0;
   wire srb_flag_type flg_rclr = buf_rd ? `SRB_FLG_RDCLR : 3'h0;
   wire srb_flag_type flg_d = flg_set | (flg_q & ~(flg_wclr | flg_rclr));

   // Bus handshake: one wait cycle, then the answer.
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q    <= SRB_BUS_IDLE;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         case (st_q)
            SRB_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  st_q   <= SRB_BUS_ANSWER;
                  wait_q <= 1'b0;
               end
               if (avs_read) begin
                  rdata_q <= rd_mux;
               end
            end
            SRB_BUS_ANSWER: begin
               st_q   <= SRB_BUS_IDLE;
               wait_q <= 1'b1;
            end
            default: begin
               st_q   <= SRB_BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // Receive buffer write-back at the end of each character.
   always_ff @(posedge mclk) begin
      if (srst) begin
         data_q    <= 16'h0000;
         lcs_q     <= 2'h0;
         cs_hold_q <= 2'h0;
      end else begin
         // The chip select is held from frame start so late control
         // changes cannot relabel a transfer already on the wire.
         if (lk.start) begin
            cs_hold_q <= chip_select_number;
         end
         if (lk.done) begin
            data_q <= lk.data;
            lcs_q  <= cs_hold_q;
         end
      end
   end

   // Status, flags and interrupt.
   always_ff @(posedge mclk) begin
      if (srst) begin
         empty_q <= 1'b1;
         ovr_q   <= 1'b0;
         berr_q  <= 1'b0;
         flg_q   <= 3'h0;
         irq_q   <= 1'b0;
      end else begin
         empty_q <= empty_d;
         ovr_q   <= ovr_d;
         berr_q  <= berr_d;
         flg_q   <= flg_d;
         irq_q   <= |(flg_q & inten_q);
      end
   end

   // Software configuration.
   always_ff @(posedge mclk) begin
      if (srst) begin
         inten_q  <= 3'h0;
         len_q    <= `SRB_CTRL_LEN_RST;
         master_q <= 1'b0;
      end else begin
         if (ien_wr) begin
            inten_q <= avs_writedata[2:0];
         end
         if (ctl_wr0) begin
            len_q <= avs_writedata[4:0];
         end
         if (ctl_wr1) begin
            master_q <= avs_writedata[`SRB_CTRL_MASTER];
         end
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq             = irq_q;

   // Checks.
   property p_berr_rdclr;
      @(posedge mclk) disable iff (srst)
      buf_rd && !lk.bit_error_status |=> !berr_q;
   endproperty
   a_berr_rdclr: assert property (p_berr_rdclr)
      else $error("Buffer read left bit-error status set.");

   property p_berr_set;
      @(posedge mclk) disable iff (srst)
      lk.bit_error_status |=> berr_q && flg_q[`SRB_FLG_BERR];
   endproperty
   a_berr_set: assert property (p_berr_set)
      else $error("Bit error did not set both status and flag.");

   property p_irq_berr;
      @(posedge mclk) disable iff (srst)
      lk.bit_error_status && inten_q[`SRB_FLG_BERR] && !ien_wr |=> ##1 irq;
   endproperty
   a_irq_berr: assert property (p_irq_berr)
      else $error("Enabled bit error raised no interrupt.");

   property p_irq_masked;
      @(posedge mclk) disable iff (srst)
      (flg_q & inten_q) == 3'h0 |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("Interrupt high with no enabled flag.");

   property p_reserved;
      @(posedge mclk) disable iff (srst)
      rd_take && (adr_buf || adr_mir) |=>
         (avs_readdata[27:18] == 10'h000) && (avs_readdata[29] == 1'b0) &&
         (!$past(adr_mir) || avs_readdata[31:16] == 16'h0000);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved read bits not zero.");

   property p_lcs;
      @(posedge mclk) disable iff (srst)
      lk.done |=> lcs_q == $past(cs_hold_q);
   endproperty
   a_lcs: assert property (p_lcs)
      else $error("Last chip select not copied on write back.");

   property p_data;
      @(posedge mclk) disable iff (srst)
      lk.done |=> data_q == $past(lk.data);
   endproperty
   a_data: assert property (p_data)
      else $error("Received word not copied into buffer.");

   property p_mirror;
      @(posedge mclk) disable iff (srst)
      mir_rd && flg_q[`SRB_FLG_RX] && !flg_wr
         |=> flg_q[`SRB_FLG_RX] ##1 avs_readdata[15:0] == $past(data_q, 2);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("Mirror read cleared a flag or showed other data.");

   property p_rdclr_flags;
      @(posedge mclk) disable iff (srst)
      buf_rd && !lk.done |=> flg_q[`SRB_FLG_RX] == 1'b0 &&
                             flg_q[`SRB_FLG_OVRN] == 1'b0;
   endproperty
   a_rdclr_flags: assert property (p_rdclr_flags)
      else $error("Buffer read did not clear overrun and receive flags.");

   property p_empty;
      @(posedge mclk) disable iff (srst)
      (buf_rd && !lk.done |=> empty_q) and (lk.done |=> !empty_q);
   endproperty
   a_empty: assert property (p_empty)
      else $error("Receive-empty status wrong after read or copy.");

   property p_overrun;
      @(posedge mclk) disable iff (srst)
      (lk.done && !empty_q |=> ovr_q) and
      (buf_rd && !lk.done |=> !ovr_q);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("Receive-overrun status wrong after copy or read.");

   property p_answer;
      @(posedge mclk) disable iff (srst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer)
      else $error("Bus request not answered after one wait cycle.");

   property p_wait_one;
      @(posedge mclk) disable iff (srst)
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("Waitrequest stayed low for more than one cycle.");

   property p_berr_view;
      @(posedge mclk) disable iff (srst)
      rd_take && adr_buf |=>
         avs_readdata[`SRB_BUF_BERR] == $past(berr_q);
   endproperty
   a_berr_view: assert property (p_berr_view)
      else $error("Buffer read showed the wrong bit-error status.");

   property p_lcs_view;
      @(posedge mclk) disable iff (srst)
      rd_take && adr_buf |=>
         avs_readdata[`SRB_BUF_LCS_LO +: 2] == $past(lcs_q);
   endproperty
   a_lcs_view: assert property (p_lcs_view)
      else $error("Buffer read showed the wrong last chip select.");

   property p_mir_view;
      @(posedge mclk) disable iff (srst)
      rd_take && adr_mir |=> avs_readdata[15:0] == $past(data_q);
   endproperty
   a_mir_view: assert property (p_mir_view)
      else $error("Mirror read showed other data than the buffer.");

   property p_mir_ovr;
      @(posedge mclk) disable iff (srst)
      mir_rd && flg_q[`SRB_FLG_OVRN] && !flg_wr |=> flg_q[`SRB_FLG_OVRN];
   endproperty
   a_mir_ovr: assert property (p_mir_ovr)
      else $error("Mirror read cleared the overrun flag.");
endmodule

// ---- src/srb_defines.svh ----
// Register map, field positions, reset values and counts of the block.
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH
// Word addresses on the register bus.
`define SRB_ADR_BUF      3'h0
`define SRB_ADR_MIRROR   3'h1
`define SRB_ADR_FLAG     3'h2
`define SRB_ADR_INTEN    3'h3
`define SRB_ADR_CTRL     3'h4
// Receive buffer status field positions.
`define SRB_BUF_EMPTY    31
`define SRB_BUF_OVR      30
`define SRB_BUF_BERR     28
`define SRB_BUF_LCS_LO   16
// Flag and interrupt enable layout.
`define SRB_FLG_BERR     0
`define SRB_FLG_OVRN     1
`define SRB_FLG_RX       2
`define SRB_FLG_RDCLR    3'h6
// Control register layout and reset.
`define SRB_CTRL_MASTER  8
`define SRB_CTRL_LEN_RST 5'h10
`define SRB_MAX_LEN      5'h10
`define SRB_ZERO_LEN     5'h00
`define SRB_CNT_ONE      5'h01
// Pin synchroniser reset levels: link clock low, chip select high.
`define SRB_PIN_RST      5'h08
`endif

// ---- src/srb_pkg.sv ----
// Types shared by the receive buffer modules.
package srb_pkg;
   typedef logic [31:0] srb_word_type;
   typedef logic [15:0] srb_data_type;
   typedef logic [1:0]  srb_cs_type;
   typedef logic [4:0]  srb_len_type;
   typedef logic [2:0]  srb_flag_type;
   typedef enum logic {
      SRB_BUS_IDLE,
      SRB_BUS_ANSWER
   } srb_bus_type;
endpackage

// ---- src/srb_if.sv ----
// Link-side signals between the register core and the shift receiver.
`timescale 1ns/1ps
interface srb_if;
   import srb_pkg::*;
   logic         sclk_s;
   logic         cs_n_s;
   logic         sdi_s;
   logic         txpin_s;
   logic         tx_bit;
   srb_len_type  char_len;
   logic         start;
   logic         done;
   srb_data_type data;
   logic         bit_error_status;
   modport core (
      output sclk_s, cs_n_s, sdi_s, txpin_s, tx_bit, char_len,
      input  start, done, data, bit_error_status
   );
   modport shift (
      input  sclk_s, cs_n_s, sdi_s, txpin_s, tx_bit, char_len,
      output start, done, data, bit_error_status
   );
endinterface

// ---- src/srb_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module srb_sync #(
   parameter int               WIDTH   = 5,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input  wire logic             mclk,
   input  wire logic             srst,
   // Pins and their synchronised copies.
   input  wire logic [WIDTH-1:0] pins,
   output logic      [WIDTH-1:0] pins_s
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge mclk) begin
      if (srst) begin
         // Resetting to the idle levels keeps a false edge out of reset.
         meta_q <= RST_VAL;
         pins_s <= RST_VAL;
      end else begin
         meta_q <= pins;
         pins_s <= meta_q;
      end
   end
endmodule

// ---- src/srb_shift.sv ----
// Serial receiver: edge finding, shift-in and bit error check.
`timescale 1ns/1ps
`include "srb_defines.svh"
module srb_shift (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Link side.
   srb_if.shift     lk
);
   import srb_pkg::*;
   logic         sclk_d_q;
   logic         cs_n_d_q;
   srb_data_type sh_q;
   srb_len_type  cnt_q;
   logic         sent_q;
   logic         done_q;
   srb_data_type data_q;
   logic         berr_q;
   wire          rise = lk.sclk_s & ~sclk_d_q;
   wire          fall = ~lk.sclk_s & sclk_d_q;
   wire          active = ~lk.cs_n_s;
   wire          frame_start = active & cs_n_d_q;
   // Lengths of zero or above the field width mean a full word.
   wire          len_bad = (lk.char_len == `SRB_ZERO_LEN) ||
                           (lk.char_len > `SRB_MAX_LEN);
   wire srb_len_type  eff_len = len_bad ? `SRB_MAX_LEN : lk.char_len;
   wire srb_len_type  cnt_nx = cnt_q + `SRB_CNT_ONE;
   // A fresh character starts from zero, so short ones land right-justified.
   wire srb_data_type sh_nx = (cnt_q == `SRB_ZERO_LEN) ?
                              {15'h0000, lk.sdi_s} :
                              {sh_q[14:0], lk.sdi_s};
   wire          last = active & rise & (cnt_nx == eff_len);
   wire          mism = active & rise & (lk.txpin_s != sent_q);
   assign lk.start  = frame_start;
   assign lk.done   = done_q;
   assign lk.data   = data_q;
   assign lk.bit_error_status = berr_q;
   always_ff @(posedge mclk) begin
      sclk_d_q <= lk.sclk_s;
      cs_n_d_q <= lk.cs_n_s;
      if (srst) begin
         cnt_q <= `SRB_ZERO_LEN;
         sh_q  <= 16'h0000;
      end else if (!active) begin
         cnt_q <= `SRB_ZERO_LEN;
      end else if (rise) begin
         cnt_q <= last ? `SRB_ZERO_LEN : cnt_nx;
         sh_q  <= sh_nx;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         sent_q <= 1'b0;
         done_q <= 1'b0;
         data_q <= 16'h0000;
         berr_q <= 1'b0;
      end else begin
         // The transmit point is the frame start or a falling edge.
         if (frame_start || fall) begin
            sent_q <= lk.tx_bit;
         end
         done_q <= last;
         if (last) begin
            data_q <= sh_nx;
         end
         berr_q <= mism;
      end
   end
   property p_bit_error;
      @(posedge mclk) disable iff (srst)
      mism |=> lk.bit_error_status;
   endproperty
   a_bit_error: assert property (p_bit_error)
      else $error("Mismatch at receive point did not flag a bit error.");
   property p_right_just;
      @(posedge mclk) disable iff (srst)
      last && (eff_len == 5'h08) |=> (lk.data[15:8] == 8'h00);
   endproperty
   a_right_just: assert property (p_right_just)
      else $error("Short character not stored right-justified.");
endmodule

// ---- tb/srb_link_model.sv ----
// Behavioural external master that drives the serial link pins.
`timescale 1ns/1ps
module srb_link_model (
   // Clock.
   input  wire logic mclk,
   // Pin choice and the bit the device sends.
   input  wire logic master_sel,
   input  wire logic tx_bit,
   // Link pins.
   output logic      spi_clk_pin,
   output logic      spi_cs_n_pin,
   output logic      serial_data_in_pin,
   output logic      master_out_pin,
   output logic      slave_out_pin
);
   initial begin
      spi_clk_pin = 1'b0;
      spi_cs_n_pin = 1'b1;
      serial_data_in_pin = 1'b0;
      master_out_pin = 1'b0;
      slave_out_pin = 1'b0;
   end

   // The unused readback pin carries the inverse, so a wrong pin choice
   // inside the device shows up as a bit error.
   task automatic frame(input int len, input logic [15:0] d, input int eb);
      logic bad;
      @(posedge mclk);
      spi_cs_n_pin <= 1'b0;
      for (int i = len - 1; i >= 0; i--) begin
         bad = (i == eb);
         serial_data_in_pin <= d[i];
         master_out_pin <= master_sel ? tx_bit ^ bad : ~tx_bit;
         slave_out_pin  <= master_sel ? ~tx_bit : tx_bit ^ bad;
         repeat (4) @(posedge mclk);
         spi_clk_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         spi_clk_pin <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      spi_cs_n_pin <= 1'b1;
      // The released data line must not keep showing the last bit.
      serial_data_in_pin <= ~serial_data_in_pin;
   endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the receive buffer and status block.
`timescale 1ns/1ps
`include "srb_defines.svh"
module tb;
   import srb_pkg::*;
   logic         mclk = 1'b0;
   logic         srst = 1'b1;
   logic [2:0]   avs_address = 3'h0;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   srb_word_type avs_writedata = 32'h0000_0000;
   srb_word_type avs_readdata;
   logic         avs_waitrequest;
   logic         tx_bit = 1'b0;
   srb_cs_type   chip_select_number = 2'h0;
   logic         master_sel = 1'b0;
   logic         irq;
   logic         sclk;
   logic         cs_n;
   logic         sdi;
   logic         mo;
   logic         so;
   int           err_count = 0;
   int           checks_done = 0;

   always #12.5 mclk = ~mclk;

   srb_top i_dut (
      .mclk               (mclk),
      .srst               (srst),
      .avs_address        (avs_address),
      .avs_read           (avs_read),
      .avs_write          (avs_write),
      .avs_writedata      (avs_writedata),
      .avs_byteenable     (4'hf),
      .avs_readdata       (avs_readdata),
      .avs_waitrequest    (avs_waitrequest),
      .spi_clk_pin        (sclk),
      .spi_cs_n_pin       (cs_n),
      .serial_data_in_pin (sdi),
      .master_out_pin     (mo),
      .slave_out_pin      (so),
      .tx_bit             (tx_bit),
      .chip_select_number (chip_select_number),
      .irq                (irq)
   );

   srb_link_model i_link (
      .mclk               (mclk),
      .master_sel         (master_sel),
      .tx_bit             (tx_bit),
      .spi_clk_pin        (sclk),
      .spi_cs_n_pin       (cs_n),
      .serial_data_in_pin (sdi),
      .master_out_pin     (mo),
      .slave_out_pin      (so)
   );

   task automatic give_verdict;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input srb_word_type got, input srb_word_type exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One register bus cycle, held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [2:0] a,
                      input srb_word_type wd, output srb_word_type q);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         err_count++;
         give_verdict();
      end
   endtask

   task automatic rdc(input logic [2:0] a, input srb_word_type exp);
      srb_word_type q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask

   task automatic wr(input logic [2:0] a, input srb_word_type d);
      srb_word_type q;
      bus(1'b1, a, d, q);
   endtask

   function automatic srb_word_type exp_buf(input logic e, input logic o,
      input logic b, input srb_cs_type c, input srb_data_type d);
      return {e, o, 1'b0, b, 10'h000, c, d};
   endfunction

   // A length of zero or above sixteen means a full sixteen-bit word.
   function automatic int eff_len(input int l);
      return (l == 0 || l > 16) ? 16 : l;
   endfunction

   task automatic xfer(input int l, input int eb, output srb_data_type d,
                       output srb_cs_type c);
      d = 16'($urandom) & 16'((32'h1 << eff_len(l)) - 1);
      c = 2'($urandom);
      chip_select_number <= c;
      tx_bit <= 1'($urandom);
      i_link.frame(eff_len(l), d, eb);
      repeat (8) @(posedge mclk);
   endtask

   initial begin
      srb_data_type d;
      srb_data_type d2;
      srb_cs_type   c;
      int           eb;
      int           lens [5] = '{1, 5, 16, 0, 17};
      void'($urandom(32'hb07f_38ed));
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      rdc(`SRB_ADR_MIRROR, 32'h0000_0000);
      rdc(`SRB_ADR_BUF, exp_buf(1'b1, 1'b0, 1'b0, 2'h0, 16'h0000));
      rdc(3'h7, 32'h0000_0000);
      foreach (lens[i]) begin
         wr(`SRB_ADR_CTRL, 32'(lens[i]));
         xfer(lens[i], -1, d, c);
         rdc(`SRB_ADR_MIRROR, {16'h0000, d});
         rdc(`SRB_ADR_FLAG, 32'h0000_0004);
         wr(`SRB_ADR_BUF, 32'hffff_ffff);
         rdc(`SRB_ADR_BUF, exp_buf(1'b0, 1'b0, 1'b0, c, d));
         rdc(`SRB_ADR_FLAG, 32'h0000_0000);
         rdc(`SRB_ADR_BUF, exp_buf(1'b1, 1'b0, 1'b0, c, d));
      end
      // Two words without a read in between; the mirror must not clear.
      xfer(16, -1, d, c);
      xfer(16, -1, d2, c);
      rdc(`SRB_ADR_MIRROR, {16'h0000, d2});
      rdc(`SRB_ADR_FLAG, 32'h0000_0006);
      rdc(`SRB_ADR_BUF, exp_buf(1'b0, 1'b1, 1'b0, c, d2));
      rdc(`SRB_ADR_FLAG, 32'h0000_0000);
      rdc(`SRB_ADR_BUF, exp_buf(1'b1, 1'b0, 1'b0, c, d2));
      for (int m = 0; m < 2; m++) begin
         master_sel <= (m == 1);
         wr(`SRB_ADR_CTRL, 32'(m << 8) | 32'h0000_0008);
         wr(`SRB_ADR_INTEN, 32'h0000_0001);
         xfer(8, -1, d, c);
         rdc(`SRB_ADR_BUF, exp_buf(1'b0, 1'b0, 1'b0, c, d));
         wr(`SRB_ADR_FLAG, 32'h0000_0007);
         eb = $urandom % 8;
         xfer(8, eb, d, c);
         check({31'h0, irq}, 32'h0000_0001);
         rdc(`SRB_ADR_BUF, exp_buf(1'b0, 1'b0, 1'b1, c, d));
         rdc(`SRB_ADR_BUF, exp_buf(1'b1, 1'b0, 1'b0, c, d));
         rdc(`SRB_ADR_FLAG, 32'h0000_0001);
         wr(`SRB_ADR_FLAG, 32'h0000_0001);
         repeat (2) @(posedge mclk);
         check({31'h0, irq}, 32'h0000_0000);
         wr(`SRB_ADR_INTEN, 32'h0000_0000);
         xfer(8, 0, d, c);
         check({31'h0, irq}, 32'h0000_0000);
         rdc(`SRB_ADR_BUF, exp_buf(1'b0, 1'b0, 1'b1, c, d));
         wr(`SRB_ADR_FLAG, 32'h0000_0007);
      end
      give_verdict();
   end
endmodule
